/* File: dv/testbench.sv */
// Self-checking bench for the command decoder and strobe monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef logic [9:0] wsmd_row_t;
    localparam logic [7:0] ST = wsmd_pkg::STATUS_OFS;
    localparam logic [7:0] LA = wsmd_pkg::LAT_OFS;
    localparam logic [31:0] LDEF = {2'h0, wsmd_pkg::GAP_RST, wsmd_pkg::OFF_RST,
        wsmd_pkg::ON_RST, wsmd_pkg::RL_RST, wsmd_pkg::WL_RST};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic ckPin, ckePin, csPin, dqsPin, dqsNPin, wrE, rdE;
    logic [5:0] caPin, burstBeats;
    logic trainWrStart, trainRdStart, oscRun, zqStart, zqLatch;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] ckRise = '0, wrCnt = '0, rdCnt = '0, zqCnt = '0, zlCnt = '0;
    logic [31:0] wrAt, rdAt, d, c0, w0, r0, z0, l0;
    logic [6:0] lastOp = 7'h00;
    // Rows: operand, zq start, zq latch, oscillator level
    wsmd_row_t rows [10] = '{10'h000, 10'h038, 10'h259, 10'h229, 10'h268,
        10'h27C, 10'h28A, 10'h238, 10'h208, 10'h218};
    always #20 ref_clk = ~ref_clk;
    wsmd_host_model host_inst (.ckPin(ckPin), .ckePin(ckePin), .csPin(csPin),
        .caPin(caPin), .dqsPin(dqsPin), .dqsNPin(dqsNPin));
    wsmd_top wsmd_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .ckPin(ckPin), .ckePin(ckePin), .csPin(csPin), .caPin(caPin), .dqsPin(dqsPin),
        .dqsNPin(dqsNPin), .trainWrStart(trainWrStart), .trainRdStart(trainRdStart),
        .burstBeats(burstBeats), .oscRun(oscRun), .zqStart(zqStart), .zqLatch(zqLatch));
    always @(posedge ckPin) ckRise <= ckRise + 1;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (zqStart === 1'b1) zqCnt <= zqCnt + 1;
        if (zqLatch === 1'b1) zlCnt <= zlCnt + 1;
        if (trainWrStart === 1'b1) begin
            wrCnt <= wrCnt + 1;
            wrAt <= ckRise;
        end
        if (trainRdStart === 1'b1) begin
            rdCnt <= rdCnt + 1;
            rdAt <= ckRise;
        end
        if (cycles == 12000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        host_inst.idle(1);
        for (int i = 0; i < 10; i++) begin
            z0 = zqCnt;
            l0 = zlCnt;
            w0 = wrCnt;
            r0 = rdCnt;
            wrE = rows[i][9:3] == wsmd_pkg::OP_WR_FIFO;
            rdE = rows[i][9:3] == wsmd_pkg::OP_RD_FIFO || rows[i][9:3] == wsmd_pkg::OP_RD_CAL;
            host_inst.multi_purpose_command(rows[i][9:3]);
            c0 = ckRise;
            host_inst.idle(32);
            if (rows[i][9]) lastOp = rows[i][9:3];
            chk(zqCnt - z0, {31'h0, rows[i][2]});
            chk(zlCnt - l0, {31'h0, rows[i][1]});
            chk({31'h0, oscRun}, {31'h0, rows[i][0]});
            chk(wrCnt - w0, {31'h0, wrE});
            chk(rdCnt - r0, {31'h0, rdE});
            if (wrE) chk(wrAt, c0 + {26'h0, wsmd_pkg::WL_RST});
            if (rdE) chk(rdAt, c0 + {26'h0, wsmd_pkg::RL_RST});
            regRead(ST, d);
            chk({25'h0, d[6:0]}, {25'h0, lastOp});
        end
        chk({26'h0, burstBeats}, 32'h10);
        regRead(wsmd_pkg::COUNT_OFS, d);
        chk({16'h0, d[15:0]}, 32'h8);
        // ****************************************
        // Hand-written cases
        // ****************************************
        w0 = wrCnt;
        host_inst.sendEdge(1'b1, 6'h20);
        host_inst.sendEdge(1'b0, 6'h07);
        host_inst.sendEdge(1'b1, 6'h04);
        host_inst.idle(20);
        regRead(ST, d);
        chk({31'h0, d[8]}, 32'h1);
        chk(wrCnt - w0, 32'h0);
        regWrite(ST, 32'h300);
        regRead(ST, d);
        chk({30'h0, d[9:8]}, 32'h0);
        regWrite(LA, {LDEF[31:6], 6'h05});
        w0 = wrCnt;
        host_inst.sendEdge(1'b1, 6'h20);
        host_inst.sendEdge(1'b0, 6'h07);
        host_inst.sendEdge(1'b1, {1'b0, wsmd_pkg::CAS2_CODE});
        host_inst.sendEdge(1'b0, 6'h15);
        c0 = ckRise;
        host_inst.idle(10);
        chk(wrCnt - w0, 32'h1);
        chk(wrAt, c0 + 32'h5);
        regRead(ST, d);
        chk({31'h0, d[8]}, 32'h1);
        host_inst.setLine(1'b1, 1'b1);
        host_inst.idle(3);
        host_inst.setLine(1'b1, 1'b0);
        regRead(ST, d);
        chk({31'h0, d[9]}, 32'h1);
        regWrite(ST, 32'h300);
        host_inst.setLine(1'b0, 1'b1);
        host_inst.multi_purpose_command(wsmd_pkg::OP_OSC_START);
        host_inst.setLine(1'b1, 1'b0);
        host_inst.idle(2);
        chk({31'h0, oscRun}, 32'h0);
        regRead(ST, d);
        chk({31'h0, d[9]}, 32'h0);
        host_inst.multi_purpose_command(wsmd_pkg::OP_OSC_START);
        chk({31'h0, oscRun}, 32'h1);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1 chk({31'h0, oscRun}, 32'h0);
        chk({26'h0, burstBeats}, 32'h10);
        regRead(wsmd_pkg::CTRL_OFS, d);
        chk(d, {29'h0, wsmd_pkg::CTRL_RST});
        regRead(LA, d);
        chk(d, LDEF);
        regRead(wsmd_pkg::COUNT_OFS, d);
        chk(d, 32'h0);
        regWrite(8'h10, 32'hFFFFFFFF);
        regRead(8'h10, d);
        chk(d, 32'h0);
        // Window mode: early, toggling and static equal pair
        regWrite(wsmd_pkg::CTRL_OFS, 32'h3);
        host_inst.idle(1);
        host_inst.multi_purpose_command(wsmd_pkg::OP_WR_FIFO);
        host_inst.setStrobe(1'b1, 1'b1);
        host_inst.idle(5);
        regRead(ST, d);
        chk({31'h0, d[9]}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            host_inst.setStrobe(k[0], k[0]);
            host_inst.idle(1);
        end
        regRead(ST, d);
        chk({31'h0, d[9]}, 32'h0);
        host_inst.idle(1);
        regRead(ST, d);
        chk({31'h0, d[9]}, 32'h1);
        regWrite(ST, 32'h200);
        // Read exception end: 28+8+1+1 with termination, 28+8+1+7 without
        for (int k = 0; k < 2; k++) begin
            regWrite(wsmd_pkg::CTRL_OFS, k ? 32'h1 : 32'h5);
            host_inst.setStrobe(1'b0, 1'b1);
            host_inst.multi_purpose_command(wsmd_pkg::OP_RD_FIFO);
            host_inst.setStrobe(1'b0, 1'b0);
            host_inst.idle(k ? 44 : 38);
            regRead(ST, d);
            chk({31'h0, d[9]}, 32'h0);
            host_inst.idle(1);
            regRead(ST, d);
            chk({31'h0, d[9]}, 32'h1);
            regWrite(ST, 32'h200);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: dv/wsmd_host_model.sv */
// Host controller model driving the command bus and write strobes
`timescale 1ns/1ps
`default_nettype none
module wsmd_host_model (
    output var logic ckPin,
    output var logic ckePin,
    output var logic csPin,
    output var logic [5:0] caPin,
    output var logic dqsPin,
    output var logic dqsNPin
);
    // Read-based scheme: pair differential, complement held high
    initial begin
        ckPin = 1'b0;
        ckePin = 1'b1;
        csPin = 1'b0;
        caPin = 6'h00;
        dqsPin = 1'b0;
        dqsNPin = 1'b1;
    end
    // Complement goes low only when a scenario asks for it
    task automatic setLine(input logic cke, input logic bad);
        ckePin <= cke;
        dqsNPin <= ~bad;
    endtask
    // Pair levels change right after a link falling edge
    task automatic setStrobe(input logic p, input logic n);
        dqsPin <= p;
        dqsNPin <= n;
    endtask
    // One link clock period; the clock stands still between calls
    task automatic sendEdge(input logic cs, input logic [5:0] ca);
        csPin <= cs;
        caPin <= ca;
        #157 ckPin <= 1'b1;
        #160 ckPin <= 1'b0;
        #3;
    endtask
    task automatic idle(input int n);
        repeat (n) sendEdge(1'b0, 6'h00);
    endtask
    // Training code over two edges, column-second straight after
    task automatic multi_purpose_command(input logic [6:0] op);
        sendEdge(1'b1, {op[6], 5'h00});
        sendEdge(1'b0, op[5:0]);
        if (op == 7'h41 || op == 7'h43 || op == 7'h47) begin
            sendEdge(1'b1, {1'b0, wsmd_pkg::CAS2_CODE});
            sendEdge(1'b0, 6'h00);
        end
    endtask
endmodule
`default_nettype wire

/* File: hdl/wsmd_lat_if.sv */
// Interface between the decoder and a latency timer
`timescale 1ns/1ps
`default_nettype none
interface wsmd_lat_if;
    logic tick;
    logic start;
    logic [5:0] cycles;
    logic done;
    modport ctrl (output tick, output start, output cycles, input done);
    modport tmr (input tick, input start, input cycles, output done);
endinterface
`default_nettype wire

/* File: hdl/wsmd_lat_timer.sv */
// Counts link clock edges and pulses when a latency has elapsed
`timescale 1ns/1ps
`default_nettype none
module wsmd_lat_timer (
    input wire logic clk,
    input wire logic rst_n,
    wsmd_lat_if.tmr lat
);
    logic [5:0] count_q;
    logic [5:0] count_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    assign lat.done = done_q;
    always_comb begin
        count_d = count_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (lat.start) begin
            count_d = lat.cycles;
            busy_d = 1'b1;
        end else if (busy_q && lat.tick) begin
            if (count_q <= 6'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                count_d = count_q - 6'h01;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end
    a_done_needs_busy: assert property (@(posedge clk) disable iff (!rst_n)
        done_q |-> $past(busy_q) && $past(lat.tick))
        else $error("latency pulse without a running count");
endmodule
`default_nettype wire

/* File: hdl/wsmd_pkg.sv */
// Constants for the write strobe monitor and multi-purpose command decoder
package wsmd_pkg;
    // ******************************************
    // Register map
    // ******************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LAT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0C;
    localparam int CTRL_CHK_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_ODT_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    localparam int LAT_WL_POS = 0;
    localparam int LAT_RL_POS = 6;
    localparam int LAT_ON_POS = 12;
    localparam int LAT_OFF_POS = 18;
    localparam int LAT_GAP_POS = 24;
    localparam logic [5:0] WL_RST = 6'h0E;
    localparam logic [5:0] RL_RST = 6'h1C;
    localparam logic [5:0] ON_RST = 6'h06;
    localparam logic [5:0] OFF_RST = 6'h1E;
    localparam logic [5:0] GAP_RST = 6'h00;
    localparam int ST_OP_POS = 0;
    localparam int ST_PEND_BIT = 7;
    localparam int ST_PROTO_BIT = 8;
    localparam int ST_STROBE_BIT = 9;
    // ******************************************
    // Command encodings
    // ******************************************
    localparam logic [4:0] MPC_CODE = 5'h00;
    localparam logic [4:0] CAS2_CODE = 5'h12;
    localparam logic [6:0] OP_RD_FIFO = 7'h41;
    localparam logic [6:0] OP_RD_CAL = 7'h43;
    localparam logic [6:0] OP_WR_FIFO = 7'h47;
    localparam logic [6:0] OP_OSC_START = 7'h4B;
    localparam logic [6:0] OP_OSC_STOP = 7'h4D;
    localparam logic [6:0] OP_ZQ_START = 7'h4F;
    localparam logic [6:0] OP_ZQ_LATCH = 7'h51;
    // ******************************************
    // Burst length in beats and timing in link clock cycles
    // ******************************************
    localparam logic [5:0] BURST_BEATS = 6'h10;
    localparam logic [7:0] BURST_CK = 8'h08;
    localparam logic [7:0] POST_CK = 8'h01;
    localparam logic [7:0] WPRE_CK = 8'h02;
    localparam logic [7:0] TA_CK = 8'h01;
    typedef enum logic [1:0] {ST_IDLE, ST_MPC2, ST_CASWAIT, ST_CAS2} wsmd_state_t;
endpackage

/* File: hdl/wsmd_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module wsmd_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] out_d;
    always_comb begin
        meta_d = din;
        out_d = meta_q;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= meta_d;
            dout <= out_d;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/wsmd_top.sv */
// Multi-purpose command decoder and write strobe monitor
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wsmd_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic ckPin,
    input wire logic ckePin,
    input wire logic csPin,
    input wire logic [5:0] caPin,
    input wire logic dqsPin,
    input wire logic dqsNPin,
    output logic trainWrStart,
    output logic trainRdStart,
    output logic [5:0] burstBeats,
    output logic oscRun,
    output logic zqStart,
    output logic zqLatch
);
    // ******************************************
    // Pin synchronisation and link edge detect
    // ******************************************
    logic [10:0] pinSync;
    logic ck, cke, cs, dqs, dqsN;
    logic [5:0] ca;
    wsmd_sync #(.W(11)) uSync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .din({ckPin, ckePin, csPin, caPin, dqsPin, dqsNPin}),
        .dout(pinSync)
    );
    assign {ck, cke, cs, ca, dqs, dqsN} = pinSync;
    logic ckPrev_q, ckeLast_q, dqsPrev_q;
    logic ckRise, cmdValid;
    assign ckRise = ck & ~ckPrev_q;
    assign cmdValid = ckRise & cke & ckeLast_q;
    // ******************************************
    // Latency timers
    // ******************************************
    wsmd_lat_if wrIf();
    wsmd_lat_if rdIf();
    wsmd_lat_timer uWrTimer (.clk(ref_clk), .rst_n(rst_n), .lat(wrIf.tmr));
    wsmd_lat_timer uRdTimer (.clk(ref_clk), .rst_n(rst_n), .lat(rdIf.tmr));
    // ******************************************
    // Registers
    // ******************************************
    logic [2:0] ctrl_q, ctrl_d;
    logic [5:0] wl_q, wl_d, rl_q, rl_d, on_q, on_d, off_q, off_d, gap_q, gap_d;
    logic [31:0] rdata_d;
    logic wrPend_q, wrPend_d, rdPend_q, rdPend_d;
    logic op6_q, op6_d, casBad_q, casBad_d;
    logic [6:0] lastOp_q, lastOp_d;
    logic protoErr_q, protoErr_d, strobeErr_q, strobeErr_d;
    logic [15:0] trainCnt_q, trainCnt_d;
    wsmd_pkg::wsmd_state_t state_q, state_d;
    logic oscRun_d, zqStart_d, zqLatch_d, wrStart_d, rdStart_d;
    logic [5:0] burst_d;
    logic [6:0] win_q, win_d;
    logic winArm_q, winArm_d;
    logic [7:0] readBusy_q, readBusy_d;
    logic launchWr, launchRd, strobeBad, inWin;
    logic [6:0] opNow;
    function automatic logic [7:0] excCycles(input logic on_die_termination, input logic [5:0] wl,
                                             input logic [5:0] on, input logic [5:0] n);
        logic [7:0] lhs;
        logic [7:0] rhs;
        lhs = {2'h0, wl} + wsmd_pkg::TA_CK;
        rhs = {2'h0, on} + wsmd_pkg::WPRE_CK + {2'h0, n};
        if (on_die_termination) begin
            excCycles = wsmd_pkg::TA_CK;
        end else begin
            excCycles = (lhs > rhs) ? lhs - rhs : 8'h00;
        end
    endfunction
    // ******************************************
    // Register bus
    // ******************************************
    always_comb begin
        ctrl_d = ctrl_q;
        wl_d = wl_q;
        rl_d = rl_q;
        on_d = on_q;
        off_d = off_q;
        gap_d = gap_q;
        rdata_d = 32'h0000_0000;
        if (regWr && regAddr == wsmd_pkg::CTRL_OFS) begin
            ctrl_d = regWdata[2:0];
        end
        if (regWr && regAddr == wsmd_pkg::LAT_OFS) begin
            wl_d = regWdata[wsmd_pkg::LAT_WL_POS +: 6];
            rl_d = regWdata[wsmd_pkg::LAT_RL_POS +: 6];
            on_d = regWdata[wsmd_pkg::LAT_ON_POS +: 6];
            off_d = regWdata[wsmd_pkg::LAT_OFF_POS +: 6];
            gap_d = regWdata[wsmd_pkg::LAT_GAP_POS +: 6];
        end
        if (regRd) begin
            unique case (regAddr)
                wsmd_pkg::CTRL_OFS: rdata_d = {29'h0, ctrl_q};
                wsmd_pkg::LAT_OFS: rdata_d = {2'h0, gap_q, off_q, on_q, rl_q, wl_q};
                wsmd_pkg::STATUS_OFS: rdata_d = {22'h0, strobeErr_q, protoErr_q,
                                                 (wrPend_q | rdPend_q), lastOp_q};
                wsmd_pkg::COUNT_OFS: rdata_d = {16'h0, trainCnt_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    // ******************************************
    // Command decoder
    // ******************************************
    always_comb begin
        state_d = state_q;
        op6_d = op6_q;
        wrPend_d = wrPend_q;
        rdPend_d = rdPend_q;
        casBad_d = casBad_q;
        lastOp_d = lastOp_q;
        trainCnt_d = trainCnt_q;
        protoErr_d = protoErr_q;
        oscRun_d = oscRun;
        zqStart_d = 1'b0;
        zqLatch_d = 1'b0;
        burst_d = burstBeats;
        launchWr = 1'b0;
        launchRd = 1'b0;
        opNow = {op6_q, ca};
        if (regWr && regAddr == wsmd_pkg::STATUS_OFS && regWdata[wsmd_pkg::ST_PROTO_BIT]) begin
            protoErr_d = 1'b0;
        end
        if (cmdValid) begin
            unique case (state_q)
                wsmd_pkg::ST_IDLE: begin
                    if (cs && ca[4:0] == wsmd_pkg::MPC_CODE) begin
                        op6_d = ca[5];
                        state_d = wsmd_pkg::ST_MPC2;
                    end
                end
                wsmd_pkg::ST_MPC2: begin
                    state_d = wsmd_pkg::ST_IDLE;
                    if (cs) begin
                        protoErr_d = 1'b1;
                    end else if (op6_q) begin
                        lastOp_d = opNow;
                        trainCnt_d = trainCnt_q + 16'h0001;
                        unique case (opNow)
                            wsmd_pkg::OP_RD_FIFO, wsmd_pkg::OP_RD_CAL: begin
                                rdPend_d = 1'b1;
                                state_d = wsmd_pkg::ST_CASWAIT;
                            end
                            wsmd_pkg::OP_WR_FIFO: begin
                                wrPend_d = 1'b1;
                                state_d = wsmd_pkg::ST_CASWAIT;
                            end
                            wsmd_pkg::OP_OSC_START: oscRun_d = 1'b1;
                            wsmd_pkg::OP_OSC_STOP: oscRun_d = 1'b0;
                            wsmd_pkg::OP_ZQ_START: zqStart_d = 1'b1;
                            wsmd_pkg::OP_ZQ_LATCH: zqLatch_d = 1'b1;
                            default: ;
                        endcase
                    end
                end
                wsmd_pkg::ST_CASWAIT: begin
                    if (cs && ca[4:0] == wsmd_pkg::CAS2_CODE) begin
                        casBad_d = ca[5];
                        state_d = wsmd_pkg::ST_CAS2;
                    end else if (cs) begin
                        protoErr_d = 1'b1;
                        wrPend_d = 1'b0;
                        rdPend_d = 1'b0;
                        state_d = wsmd_pkg::ST_IDLE;
                    end
                end
                wsmd_pkg::ST_CAS2: begin
                    if (!cs) begin
                        if (casBad_q || ca != 6'h00) begin
                            protoErr_d = 1'b1;
                        end
                        launchWr = wrPend_q;
                        launchRd = rdPend_q;
                        burst_d = wsmd_pkg::BURST_BEATS;
                        wrPend_d = 1'b0;
                        rdPend_d = 1'b0;
                        state_d = wsmd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
        wrIf.tick = ckRise;
        wrIf.start = launchWr;
        wrIf.cycles = wl_q;
        rdIf.tick = ckRise;
        rdIf.start = launchRd;
        rdIf.cycles = rl_q;
        wrStart_d = wrIf.done;
        rdStart_d = rdIf.done;
    end
    // ******************************************
    // Write strobe monitor
    // ******************************************
    always_comb begin
        win_d = win_q;
        winArm_d = winArm_q;
        readBusy_d = readBusy_q;
        strobeErr_d = strobeErr_q;
        inWin = winArm_q && win_q >= {1'b0, on_q} && win_q < {1'b0, off_q};
        strobeBad = 1'b0;
        if (regWr && regAddr == wsmd_pkg::STATUS_OFS && regWdata[wsmd_pkg::ST_STROBE_BIT]) begin
            strobeErr_d = 1'b0;
        end
        if (ckRise) begin
            if (winArm_q) begin
                win_d = win_q + 7'h01;
                winArm_d = win_q < {1'b0, off_q};
            end
            if (readBusy_q != 8'h00) begin
                readBusy_d = readBusy_q - 8'h01;
            end
            if (ctrl_q[wsmd_pkg::CTRL_MODE_BIT]) begin
                strobeBad = inWin && dqs == dqsN;
            end else if (winArm_q) begin
                strobeBad = dqs == dqsN;
            end else begin
                strobeBad = !dqsN;
            end
            // Toggling strobe, read traffic or CKE low never flag
            if (ctrl_q[wsmd_pkg::CTRL_CHK_BIT] && cke && readBusy_q == 8'h00
                && dqs == dqsPrev_q && strobeBad) begin
                strobeErr_d = 1'b1;
            end
        end
        if (launchWr) begin
            win_d = 7'h00;
            winArm_d = 1'b1;
        end
        if (launchRd) begin
            readBusy_d = {2'h0, rl_q} + wsmd_pkg::BURST_CK + wsmd_pkg::POST_CK
                + excCycles(ctrl_q[wsmd_pkg::CTRL_ODT_BIT], wl_q, on_q, gap_q);
        end
    end
    // ******************************************
    // State registers
    // ******************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ckPrev_q <= 1'b0;
            ckeLast_q <= 1'b0;
            dqsPrev_q <= 1'b0;
            ctrl_q <= wsmd_pkg::CTRL_RST;
            wl_q <= wsmd_pkg::WL_RST;
            rl_q <= wsmd_pkg::RL_RST;
            on_q <= wsmd_pkg::ON_RST;
            off_q <= wsmd_pkg::OFF_RST;
            gap_q <= wsmd_pkg::GAP_RST;
            regRdata <= 32'h0000_0000;
            state_q <= wsmd_pkg::ST_IDLE;
            op6_q <= 1'b0;
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            casBad_q <= 1'b0;
            lastOp_q <= 7'h00;
            trainCnt_q <= 16'h0000;
            protoErr_q <= 1'b0;
            strobeErr_q <= 1'b0;
            oscRun <= 1'b0;
            zqStart <= 1'b0;
            zqLatch <= 1'b0;
            burstBeats <= wsmd_pkg::BURST_BEATS;
            trainWrStart <= 1'b0;
            trainRdStart <= 1'b0;
            win_q <= 7'h00;
            winArm_q <= 1'b0;
            readBusy_q <= 8'h00;
        end else begin
            ckPrev_q <= ck;
            ckeLast_q <= ckRise ? cke : ckeLast_q;
            dqsPrev_q <= ckRise ? dqs : dqsPrev_q;
            ctrl_q <= ctrl_d;
            wl_q <= wl_d;
            rl_q <= rl_d;
            on_q <= on_d;
            off_q <= off_d;
            gap_q <= gap_d;
            regRdata <= rdata_d;
            state_q <= state_d;
            op6_q <= op6_d;
            wrPend_q <= wrPend_d;
            rdPend_q <= rdPend_d;
            casBad_q <= casBad_d;
            lastOp_q <= lastOp_d;
            trainCnt_q <= trainCnt_d;
            protoErr_q <= protoErr_d;
            strobeErr_q <= strobeErr_d;
            oscRun <= oscRun_d;
            zqStart <= zqStart_d;
            zqLatch <= zqLatch_d;
            burstBeats <= burst_d;
            trainWrStart <= wrStart_d;
            trainRdStart <= rdStart_d;
            win_q <= win_d;
            winArm_q <= winArm_d;
            readBusy_q <= readBusy_d;
        end
    end
    // ******************************************
    // Checks
    // ******************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic mpcSecond;
    assign mpcSecond = cmdValid && state_q == wsmd_pkg::ST_MPC2 && !cs;
    a_op6_capture: assert property (
        cmdValid && state_q == wsmd_pkg::ST_IDLE && cs && ca[4:0] == 5'h00
        |=> state_q == wsmd_pkg::ST_MPC2 && op6_q == $past(ca[5]))
        else $error("first edge operand bit not captured");
    a_nop_no_effect: assert property (
        mpcSecond && !op6_q |=> state_q == wsmd_pkg::ST_IDLE && $stable(trainCnt_q))
        else $error("no-op command had an effect");
    a_train_awaits_cas: assert property (
        mpcSecond && op6_q && (opNow == 7'h41 || opNow == 7'h43 || opNow == 7'h47)
        |=> state_q == wsmd_pkg::ST_CASWAIT)
        else $error("training read or write not waiting for column-second");
    a_reserved_ignored: assert property (
        mpcSecond && op6_q && opNow == 7'h45 |=> state_q == wsmd_pkg::ST_IDLE
        && $stable(oscRun) && !zqStart && !zqLatch)
        else $error("reserved code had an effect");
    a_osc_follows_op: assert property (
        mpcSecond && op6_q && opNow == 7'h4B |=> oscRun)
        else $error("oscillator did not start");
    a_cas_break_flag: assert property (
        cmdValid && state_q == wsmd_pkg::ST_CASWAIT && cs && ca[4:0] != 5'h12
        |=> protoErr_q)
        else $error("broken training pair not flagged");
    a_wr_latency_start: assert property (
        cmdValid && state_q == wsmd_pkg::ST_CAS2 && !cs && wrPend_q
        |-> wrIf.start && wrIf.cycles == wl_q ##1 burstBeats == 6'h10)
        else $error("write latency not started from column-second");
    a_cke_low_quiet: assert property (
        ckRise && !cke && !strobeErr_q |=> !strobeErr_q)
        else $error("strobe flagged while CKE low");
    a_read_exempt: assert property (
        ckRise && readBusy_q != 8'h00 && !strobeErr_q |=> !strobeErr_q)
        else $error("strobe flagged during read exception");
    c_train_write: cover property (trainWrStart);
    c_train_read: cover property (trainRdStart);
    c_proto_error: cover property ($rose(protoErr_q));
    c_strobe_error: cover property ($rose(strobeErr_q));
endmodule
`default_nettype wire
